// *** bench/sbds_mem_model.sv ***
`timescale 1ns/1ps
module sbds_mem_model
(
   // Clock
   input wire logic i_clk,
   // Write-back from the block and bench preload
   input wire logic i_we,
   input wire logic [7:0] i_wdata,
   input wire logic i_load,
   input wire logic [7:0] i_load_val,
   // Addressed byte
   output logic [7:0] o_byte
);
   // Write-back wins over a preload in the same cycle
   always_ff @(posedge i_clk)
   begin
      if (i_we)
         o_byte <= i_wdata;
      else if (i_load)
         o_byte <= i_load_val;
   end
endmodule : sbds_mem_model

// *** bench/testbench.sv ***
`timescale 1ns/1ps
`define CHK(a, b) \
   begin \
      total_checks++; \
      if ((a) !== (b)) \
      begin \
         err_count++; \
         $display("BAD %0t got %h exp %h", $time, (a), (b)); \
      end \
   end
module testbench;
   logic I_CLK = 0;
   logic I_RST_N = 0;
   logic ld = 1;
   sbds_pkg::sbds_req_t req = '0;
   sbds_pkg::sbds_flags_t flags, f;
   logic [7:0] work, wdata, mbyte, w, wd;
   logic we, skip, we_e, sk_e;
   int err_count = 0;
   int total_checks = 0;
   int seed = 32'h0cd4;
   always #2 I_CLK = ~I_CLK;
   sbds_alu u_dut (.I_CLK(I_CLK), .I_RST_N(I_RST_N), .I_REQ(req), .O_WORK(work),
      .O_FLAGS(flags), .O_MEM_WE(we), .O_MEM_WDATA(wdata), .O_SKIP(skip));
   sbds_mem_model u_mem (.i_clk(I_CLK), .i_we(we), .i_wdata(wdata), .i_load(ld),
      .i_load_val(8'h80), .o_byte(mbyte));
   ////////////////////////////////////////////////////////////////////////////
   // Reference: state after the edge that samples r
   function automatic void step(sbds_pkg::sbds_req_t r);
      int nb;
      int u;
      int s;
      int h;
      logic [7:0] d;
      logic take;
      take = !sk_e && r.valid && r.op != sbds_pkg::SBDS_OP_NONE;
      sk_e = 0;
      we_e = 0;
      if (!take)
         return;
      // Exact integer arithmetic, so flags follow from sign and range
      nb = !f.borrow_inverse;
      u = int'(w) - int'(r.operand) - nb;
      s = int'($signed(w)) - int'($signed(r.operand)) - nb;
      h = int'(w[3:0]) - int'(r.operand[3:0]) - nb;
      d = r.operand - 8'h01;
      if (r.op == sbds_pkg::SBDS_OP_SUB_IMM || r.op == sbds_pkg::SBDS_OP_SUB_MEM)
      begin
         f.signed_range_fault = (s < -128) || (s > 127);
         f.signed_borrow = s < 0;
         f.result_null = u[7:0] == 8'h00;
         f.chained_null = f.result_null && f.chained_null;
         f.half_borrow = h >= 0;
         f.borrow_inverse = u >= 0;
      end
      case (r.op)
         sbds_pkg::SBDS_OP_SUB_IMM: w = u[7:0];
         sbds_pkg::SBDS_OP_SUB_MEM: {we_e, wd} = {1'b1, u[7:0]};
         sbds_pkg::SBDS_OP_DEC_MEM: {we_e, wd, sk_e} = {1'b1, d, d == 8'h00};
         default: {w, sk_e} = {d, d == 8'h00};
      endcase
   endfunction : step
   task automatic report_and_stop();
      if (err_count == 0 && total_checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : report_and_stop
   ////////////////////////////////////////////////////////////////////////////
   initial
   begin
      {w, wd, f, we_e, sk_e} = '0;
      repeat (4) @(posedge I_CLK);
      #1 I_RST_N = 1;
      ld = 0;
      for (int i = 0; i < 3000; i++)
      begin
         @(posedge I_CLK);
         #1;
         `CHK(work, w)
         `CHK(flags, f)
         `CHK(skip, sk_e)
         `CHK(we, we_e)
         if (we_e)
            `CHK(wdata, wd)
         // Operand 1 and 0 hit the skip and borrow edges often
         req.valid = ($random(seed) & 7) != 0;
         req.op = sbds_pkg::sbds_op_t'({$random(seed)} % 5);
         req.operand = (i % 4 == 0) ? 8'h01 : (i % 7 == 0) ? mbyte :
            (i % 9 == 0) ? 8'h00 : 8'($random(seed));
         step(req);
      end
      report_and_stop();
   end
endmodule : testbench

// *** design/sbds_alu.sv ***
`timescale 1ns/1ps
`include "sbds_cfg.svh"
// Function
// - Immediate subtract-with-borrow writes work minus operand minus not-borrow to work.
// - Borrow-inverse bit is cleared on a negative difference and set on zero or positive.
// - Memory subtract-with-borrow computes the same difference but stores it to memory.
// - Both subtracts update range fault, null, half borrow, borrow inverse, signed and chained.
// - Decrement-to-memory stores byte minus one and skips the next instruction on zero.
// - A skip inserts one dummy cycle so the operation takes two instruction cycles.
// - Decrement-to-work puts byte minus one in work, memory untouched, skip on zero.
module sbds_alu
(
   // Clock and reset
   input wire logic I_CLK,
   input wire logic I_RST_N,
   // Request from decoder, operand is immediate or memory byte
   input wire sbds_pkg::sbds_req_t I_REQ,
   // Work register and flags
   output logic [7:0] O_WORK,
   output sbds_pkg::sbds_flags_t O_FLAGS,
   // Memory write-back
   output logic O_MEM_WE,
   output logic [7:0] O_MEM_WDATA,
   // Fetch pipeline: dummy cycle in progress
   output logic O_SKIP
);

   ////////////////////////////////////////////////////////////////////////////
   logic [7:0] work_r;
   sbds_pkg::sbds_flags_t flags_r;
   logic mem_we_r;
   logic [7:0] mem_wdata_r;
   logic skip_r;

   logic is_sub;
   logic is_dec;
   logic [8:0] diff;
   logic [4:0] low_diff;
   logic [7:0] dec_val;
   logic nb;
   logic ovf;
   logic take_sub_imm;
   logic take_sub_mem;
   logic take_dec_mem;
   logic take_dec_work;
   // Assertion helper: number of dummy cycles before the current one in this run
   logic [1:0] skip_run_r;

   ////////////////////////////////////////////////////////////////////////////
   // Op class decode, shared by datapath and checks
   function automatic logic op_is_sub(input sbds_pkg::sbds_op_t op);
      op_is_sub = (op == sbds_pkg::SBDS_OP_SUB_IMM) || (op == sbds_pkg::SBDS_OP_SUB_MEM);
   endfunction : op_is_sub

   function automatic logic op_is_dec(input sbds_pkg::sbds_op_t op);
      op_is_dec = (op == sbds_pkg::SBDS_OP_DEC_MEM) || (op == sbds_pkg::SBDS_OP_DEC_WORK);
   endfunction : op_is_dec

   // The dummy cycle swallows whatever the decoder presents
   function automatic logic req_taken(input sbds_pkg::sbds_req_t req, input logic skipping);
      req_taken = req.valid && !skipping;
   endfunction : req_taken

   always_comb
   begin
      is_sub = req_taken(I_REQ, skip_r) && op_is_sub(I_REQ.op);
      is_dec = req_taken(I_REQ, skip_r) && op_is_dec(I_REQ.op);
      take_sub_imm = is_sub && (I_REQ.op == sbds_pkg::SBDS_OP_SUB_IMM);
      take_sub_mem = is_sub && (I_REQ.op == sbds_pkg::SBDS_OP_SUB_MEM);
      take_dec_mem = is_dec && (I_REQ.op == sbds_pkg::SBDS_OP_DEC_MEM);
      take_dec_work = is_dec && (I_REQ.op == sbds_pkg::SBDS_OP_DEC_WORK);
      nb = ~flags_r.borrow_inverse;
      // Ninth bit is borrow out
      diff = {1'b0, work_r} - {1'b0, I_REQ.operand} - {8'h00, nb};
      low_diff = {1'b0, work_r[3:0]} - {1'b0, I_REQ.operand[3:0]} - {4'h0, nb};
      ovf = (work_r[7] != I_REQ.operand[7]) && (diff[7] != work_r[7]);
      dec_val = I_REQ.operand - 8'h01;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Work register
   always_ff @(posedge I_CLK)
   begin
      if (!I_RST_N)
         work_r <= `SBDS_WORK_RST;
      else if (take_sub_imm)
         work_r <= diff[7:0];
      else if (take_dec_work)
         work_r <= dec_val;
   end

   // Flags: decrements never enter here
   always_ff @(posedge I_CLK)
   begin
      if (!I_RST_N)
         flags_r <= `SBDS_FLAGS_RST;
      else if (is_sub)
      begin
         flags_r.borrow_inverse <= ~diff[8];
         flags_r.half_borrow <= ~low_diff[4];
         flags_r.result_null <= (diff[7:0] == 8'h00);
         flags_r.signed_range_fault <= ovf;
         flags_r.signed_borrow <= diff[7] ^ ovf;
         // Chained zero keeps prior zero for multi-byte compares
         flags_r.chained_null <= (diff[7:0] == 8'h00) && flags_r.chained_null;
      end
   end

   // Memory write-back
   always_ff @(posedge I_CLK)
   begin
      if (!I_RST_N)
      begin
         mem_we_r <= 1'b0;
         mem_wdata_r <= 8'h00;
      end
      else
      begin
         mem_we_r <= take_sub_mem || take_dec_mem;
         // Every subtract loads the difference, so flag checks can see it
         if (is_sub)
            mem_wdata_r <= diff[7:0];
         else if (take_dec_mem)
            mem_wdata_r <= dec_val;
      end
   end

   // Dummy cycle; a request during it is the squashed instruction
   always_ff @(posedge I_CLK)
   begin
      if (!I_RST_N)
         skip_r <= 1'b0;
      else
         skip_r <= is_dec && (dec_val == 8'h00);
   end

   // Check helper only; saturates so a stuck skip cannot wrap back to legal
   always_ff @(posedge I_CLK)
   begin
      if (!I_RST_N)
         skip_run_r <= 2'h0;
      else if (!skip_r)
         skip_run_r <= 2'h0;
      else if (skip_run_r != 2'h3)
         skip_run_r <= skip_run_r + 2'h1;
   end

   assign O_WORK = work_r;
   assign O_FLAGS = flags_r;
   assign O_MEM_WE = mem_we_r;
   assign O_MEM_WDATA = mem_wdata_r;
   assign O_SKIP = skip_r;

   ////////////////////////////////////////////////////////////////////////////
   sub_imm_work_a: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
      (is_sub && I_REQ.op == sbds_pkg::SBDS_OP_SUB_IMM) |=>
      O_WORK == $past(work_r) - $past(I_REQ.operand) - {7'h00, ~$past(flags_r.borrow_inverse)})
      else $error("work not updated by immediate subtract");
   borrow_inv_a: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
      is_sub |=> O_FLAGS.borrow_inverse == ($past(diff[8]) == 1'b0))
      else $error("borrow inverse wrong");
   sub_mem_store_a: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
      (is_sub && I_REQ.op == sbds_pkg::SBDS_OP_SUB_MEM) |=>
      O_MEM_WE && O_MEM_WDATA == $past(diff[7:0]) && $stable(O_WORK))
      else $error("memory subtract store wrong");
   null_flag_a: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
      is_sub |=> O_FLAGS.result_null == (O_MEM_WDATA == 8'h00))
      else $error("null flag wrong");
   dec_skip_a: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
      (is_dec && I_REQ.op == sbds_pkg::SBDS_OP_DEC_MEM) |=>
      O_MEM_WE && O_MEM_WDATA == $past(I_REQ.operand) - 8'h01 && O_SKIP == (O_MEM_WDATA == 8'h00))
      else $error("decrement to memory wrong");
   skip_one_a: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
      O_SKIP |=> !O_SKIP ##0 !O_MEM_WE)
      else $error("dummy cycle longer than one");
   dec_work_a: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
      (is_dec && I_REQ.op == sbds_pkg::SBDS_OP_DEC_WORK) |=>
      !O_MEM_WE && O_WORK == $past(I_REQ.operand) - 8'h01 && O_SKIP == (O_WORK == 8'h00))
      else $error("decrement to work wrong");
   dec_no_flags_a: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
      is_dec |=> $stable(O_FLAGS))
      else $error("decrement changed flags");
   borrow_out_a: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
      is_sub |=> O_FLAGS.borrow_inverse ==
      ({1'b0, $past(work_r)} >= {1'b0, $past(I_REQ.operand)} + {8'h00, $past(nb)}))
      else $error("borrow out wrong");
   half_borrow_a: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
      is_sub |=> O_FLAGS.half_borrow ==
      ({1'b0, $past(work_r[3:0])} >= {1'b0, $past(I_REQ.operand[3:0])} + {4'h0, $past(nb)}))
      else $error("half borrow wrong");
   range_fault_a: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
      is_sub |=> O_FLAGS.signed_range_fault ==
      (($past(work_r[7]) != $past(I_REQ.operand[7])) && (O_MEM_WDATA[7] != $past(work_r[7]))))
      else $error("range fault wrong");
   signed_borrow_a: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
      is_sub |=> O_FLAGS.signed_borrow == (O_MEM_WDATA[7] ^ O_FLAGS.signed_range_fault))
      else $error("signed borrow wrong");
   chained_null_a: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
      is_sub |=> O_FLAGS.chained_null == (O_FLAGS.result_null && $past(flags_r.chained_null)))
      else $error("chained null wrong");
   skip_squash_a: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
      O_SKIP |=> $stable(O_WORK) && $stable(O_FLAGS))
      else $error("skipped instruction took effect");
   skip_cause_a: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
      O_SKIP |-> $past(is_dec) && ($past(I_REQ.operand) == 8'h01))
      else $error("skip without zero decrement");
   dec_mem_work_a: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
      take_dec_mem |=> $stable(O_WORK))
      else $error("memory decrement touched work");
   sub_no_skip_a: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
      is_sub |=> !O_SKIP)
      else $error("subtract caused a skip");
   idle_quiet_a: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
      !is_sub && !is_dec |=> !O_MEM_WE && !O_SKIP && $stable(O_WORK) && $stable(O_FLAGS))
      else $error("idle cycle changed state");
   skip_len_a: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
      skip_r |-> skip_run_r < 2'(`SBDS_SKIP_CYCLES))
      else $error("dummy cycle run too long");
   mem_we_cause_a: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
      O_MEM_WE |-> $past(take_sub_mem || take_dec_mem))
      else $error("stray memory write");
   wdata_hold_a: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
      !is_sub && !take_dec_mem |=> $stable(O_MEM_WDATA))
      else $error("write data moved without a store");
   reset_clear_a: assert property (@(posedge I_CLK)
      !I_RST_N |=> O_WORK == `SBDS_WORK_RST && O_FLAGS == `SBDS_FLAGS_RST && !O_MEM_WE && !O_SKIP)
      else $error("reset values wrong");

endmodule : sbds_alu

// *** design/sbds_cfg.svh ***
`ifndef SBDS_CFG_SVH
`define SBDS_CFG_SVH
// Reset values
`define SBDS_WORK_RST 8'h00
`define SBDS_FLAGS_RST 6'h00
// Flag bit positions
`define SBDS_FLAG_C 0
`define SBDS_FLAG_AC 1
`define SBDS_FLAG_Z 2
`define SBDS_FLAG_OV 3
`define SBDS_FLAG_SC 4
`define SBDS_FLAG_CZ 5
// Skip costs one dummy cycle
`define SBDS_SKIP_CYCLES 1
`endif

// *** design/sbds_pkg.sv ***
package sbds_pkg;
   typedef enum logic [2:0]
   {
      SBDS_OP_NONE,
      SBDS_OP_SUB_IMM,
      SBDS_OP_SUB_MEM,
      SBDS_OP_DEC_MEM,
      SBDS_OP_DEC_WORK
   } sbds_op_t;

   typedef struct packed
   {
      logic chained_null;
      logic signed_borrow;
      logic signed_range_fault;
      logic result_null;
      logic half_borrow;
      logic borrow_inverse;
   } sbds_flags_t;

   typedef struct packed
   {
      logic valid;
      sbds_op_t op;
      logic [7:0] operand;
   } sbds_req_t;
endpackage : sbds_pkg
